// ---- hdl/xadl_pkg.sv ----
package xadl_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses on the AXI4-Lite port
    // ------------------------------------------------------------
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] OFS_INSTR   = 8'h00;
    localparam logic [7:0] OFS_ACC     = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_FADDR   = 8'h0C;
    localparam logic [7:0] OFS_FDATA   = 8'h10;
    localparam logic [7:0] OFS_DIR_A   = 8'h14;
    localparam logic [7:0] OFS_DIR_B   = 8'h18;
    localparam logic [7:0] OFS_DIR_C   = 8'h1C;
    localparam logic [7:0] OFS_ERR     = 8'h20;

    // ------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------
    localparam int         OPND_LSB    = 0;
    localparam int         DEST_BIT    = 8;
    localparam int         OPC_LSB     = 16;
    localparam int         FILE_AW     = 7;
    localparam int         FILE_DEPTH  = 128;

    typedef enum logic [1:0]
    {
        XADL_OPC_NONE     = 2'h0,
        XADL_OPC_LIT_XOR  = 2'h1,
        XADL_OPC_FILE_XOR = 2'h2,
        XADL_OPC_DIR_LOAD = 2'h3
    } xadl_opcode_type;

    // Direction-load operand codes
    localparam logic [7:0] DIR_SEL_A   = 8'h05;
    localparam logic [7:0] DIR_SEL_LO  = 8'h05;
    localparam logic [7:0] DIR_SEL_HI  = 8'h07;
    localparam int         DIR_COUNT   = 3;

    // ------------------------------------------------------------
    // Status and error bits, reset values, responses
    // ------------------------------------------------------------
    localparam int         STAT_C      = 0;
    localparam int         STAT_DC     = 1;
    localparam int         STAT_Z      = 2;
    localparam int         ERR_DIR     = 0;
    localparam int         ERR_FILE    = 1;
    localparam logic [7:0] ACC_RST     = 8'h00;
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic [7:0] DIR_RST     = 8'hFF;
    localparam logic [6:0] FADDR_RST   = 7'h00;
    localparam logic [1:0] ERR_RST     = 2'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hdl/xadl_core.sv ----
`timescale 1ns/1ps

module xadl_core
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [7:0]       accumulator,
    output logic [7:0]       status_flags,
    output logic [7:0]       port_a_direction,
    output logic [7:0]       port_b_direction,
    output logic [7:0]       port_c_direction
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // True for any offset that answers OKAY
    function automatic logic xadl_mapped(input logic [7:0] a);
        xadl_mapped = (a == xadl_pkg::OFS_INSTR)  ||
                      (a == xadl_pkg::OFS_ACC)    ||
                      (a == xadl_pkg::OFS_STATUS) ||
                      (a == xadl_pkg::OFS_FADDR)  ||
                      (a == xadl_pkg::OFS_FDATA)  ||
                      (a == xadl_pkg::OFS_DIR_A)  ||
                      (a == xadl_pkg::OFS_DIR_B)  ||
                      (a == xadl_pkg::OFS_DIR_C)  ||
                      (a == xadl_pkg::OFS_ERR);
    endfunction

    // Byte-lane 0 merge for the 8-bit registers
    function automatic logic [7:0] xadl_lane0(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic       strb);
        xadl_lane0 = strb ? new_v : old_v;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0]  acc_ff;
    logic [7:0]  status_ff;
    logic [6:0]  faddr_ff;
    logic [1:0]  err_ff;
    logic [7:0]  dir_ff [0:xadl_pkg::DIR_COUNT-1];
    logic [7:0]  file_mem [0:xadl_pkg::FILE_DEPTH-1];

    // ------------------------------------------------------------
    // Write channel handshakes
    // ------------------------------------------------------------

    // Address and data are taken in either order, then joined
    wire         aw_take     = s_axi_awvalid & awready_ff;
    wire         w_take      = s_axi_wvalid & wready_ff;
    wire         wr_fire     = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire         nxt_aw_held = (aw_held_ff | aw_take) & ~wr_fire;
    wire         nxt_w_held  = (w_held_ff | w_take) & ~wr_fire;
    wire         nxt_bvalid  = wr_fire | (bvalid_ff & ~s_axi_bready);
    wire  [1:0]  nxt_bresp   = xadl_mapped(awaddr_ff) ?
                               xadl_pkg::RESP_OKAY : xadl_pkg::RESP_SLVERR;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= xadl_pkg::RESP_OKAY;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awready_ff <= ~nxt_aw_held;
            wready_ff  <= ~nxt_w_held;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= wr_fire ? nxt_bresp : bresp_ff;
        end
    end

    // Payload holders carry no control meaning, so no reset needed
    always_ff @(posedge aclk)
    begin
        if (aw_take)
            awaddr_ff <= s_axi_awaddr;
        if (w_take)
        begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
    end

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    wire        strb0      = wstrb_ff[0];
    wire        wr_acc     = wr_fire & (awaddr_ff == xadl_pkg::OFS_ACC);
    wire        wr_status  = wr_fire & (awaddr_ff == xadl_pkg::OFS_STATUS);
    wire        wr_faddr   = wr_fire & (awaddr_ff == xadl_pkg::OFS_FADDR);
    wire        wr_fdata   = wr_fire & (awaddr_ff == xadl_pkg::OFS_FDATA);
    wire        wr_err     = wr_fire & (awaddr_ff == xadl_pkg::OFS_ERR);
    // Opcode lane must be written too, else a half word could execute
    wire        wr_instr   = wr_fire & (awaddr_ff == xadl_pkg::OFS_INSTR)
                             & wstrb_ff[0] & wstrb_ff[2];

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    wire [1:0]  opc_bits   = wdata_ff[xadl_pkg::OPC_LSB +: 2];
    wire [7:0]  operand    = wdata_ff[xadl_pkg::OPND_LSB +: 8];
    wire        dest_file  = wdata_ff[xadl_pkg::DEST_BIT];
    wire [6:0]  file_sel   = operand[6:0];
    wire        is_lit     = opc_bits == xadl_pkg::XADL_OPC_LIT_XOR;
    wire        is_file    = opc_bits == xadl_pkg::XADL_OPC_FILE_XOR;
    wire        is_dir     = opc_bits == xadl_pkg::XADL_OPC_DIR_LOAD;
    wire        file_ok    = ~operand[7];
    wire        dir_ok     = (operand >= xadl_pkg::DIR_SEL_LO) &&
                             (operand <= xadl_pkg::DIR_SEL_HI);
    wire        exec_lit   = wr_instr & is_lit;
    wire        exec_file  = wr_instr & is_file & file_ok;
    wire        exec_dir   = wr_instr & is_dir & dir_ok;

    // ------------------------------------------------------------
    // Exclusive-OR datapath
    // ------------------------------------------------------------
    wire [7:0]  file_rd    = file_mem[file_sel];
    wire [7:0]  lit_res    = acc_ff ^ operand;
    wire [7:0]  file_res   = acc_ff ^ file_rd;
    wire [7:0]  xor_res    = exec_lit ? lit_res : file_res;
    wire        xor_zero   = xor_res == 8'h00;
    wire        exec_xor   = exec_lit | exec_file;
    wire        to_acc     = exec_lit | (exec_file & ~dest_file);
    wire        to_file    = exec_file & dest_file;

    // Accumulator: instruction result wins over nothing, bus is exclusive
    wire [7:0]  nxt_acc    = to_acc ? xor_res :
                             wr_acc ? xadl_lane0(acc_ff, wdata_ff[7:0],
                                                 strb0) :
                             acc_ff;

    // Only Z is touched by an XOR; C, DC and upper bits pass through
    wire [7:0]  xor_status = {status_ff[7:xadl_pkg::STAT_Z+1],
                              xor_zero,
                              status_ff[xadl_pkg::STAT_Z-1:0]};
    wire [7:0]  nxt_status = exec_xor  ? xor_status :
                             wr_status ? xadl_lane0(status_ff, wdata_ff[7:0],
                                                    strb0) :
                             status_ff;

    wire [7:0]  faddr_new  = xadl_lane0({1'b0, faddr_ff}, wdata_ff[7:0],
                                        strb0);
    wire [6:0]  nxt_faddr  = wr_faddr ? faddr_new[6:0] : faddr_ff;

    // Sticky operand errors; a fresh error beats a clear in one cycle
    wire [1:0]  err_set    = {wr_instr & is_file & ~file_ok,
                              wr_instr & is_dir & ~dir_ok};
    wire [1:0]  err_clr    = (wr_err & strb0) ? wdata_ff[1:0] : 2'h0;
    wire [1:0]  nxt_err    = (err_ff & ~err_clr) | err_set;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_ff    <= xadl_pkg::ACC_RST;
            status_ff <= xadl_pkg::STATUS_RST;
            faddr_ff  <= xadl_pkg::FADDR_RST;
            err_ff    <= xadl_pkg::ERR_RST;
        end
        else
        begin
            acc_ff    <= nxt_acc;
            status_ff <= nxt_status;
            faddr_ff  <= nxt_faddr;
            err_ff    <= nxt_err;
        end
    end

    // ------------------------------------------------------------
    // File register array
    // ------------------------------------------------------------

    // Bus and instruction writes never coincide, one write at a time
    wire        mem_we     = to_file | (wr_fdata & strb0);
    wire [6:0]  mem_addr   = to_file ? file_sel : faddr_ff;
    wire [7:0]  mem_wd     = to_file ? file_res : wdata_ff[7:0];

    always_ff @(posedge aclk)
    begin
        if (mem_we)
            file_mem[mem_addr] <= mem_wd;
    end

    // ------------------------------------------------------------
    // Port direction registers
    // ------------------------------------------------------------

    // Operand 5, 6, 7 pick entry 0, 1, 2; flags are not involved
    genvar gi;
    generate
        for (gi = 0; gi < xadl_pkg::DIR_COUNT; gi++)
        begin : g_dir
            localparam logic [7:0] SEL = xadl_pkg::DIR_SEL_A + 8'(gi);
            wire load = exec_dir & (operand == SEL);
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    dir_ff[gi] <= xadl_pkg::DIR_RST;
                else if (load)
                    dir_ff[gi] <= acc_ff;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    wire        ar_take    = s_axi_arvalid & arready_ff;
    wire        nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
    wire [7:0]  ra         = s_axi_araddr;
    wire [7:0]  rd_byte    =
        (ra == xadl_pkg::OFS_ACC)    ? acc_ff :
        (ra == xadl_pkg::OFS_STATUS) ? status_ff :
        (ra == xadl_pkg::OFS_FADDR)  ? {1'b0, faddr_ff} :
        (ra == xadl_pkg::OFS_FDATA)  ? file_mem[faddr_ff] :
        (ra == xadl_pkg::OFS_DIR_A)  ? dir_ff[0] :
        (ra == xadl_pkg::OFS_DIR_B)  ? dir_ff[1] :
        (ra == xadl_pkg::OFS_DIR_C)  ? dir_ff[2] :
        (ra == xadl_pkg::OFS_ERR)    ? {6'h00, err_ff} :
        8'h00;
    wire [1:0]  nxt_rresp  = xadl_mapped(ra) ?
                             xadl_pkg::RESP_OKAY : xadl_pkg::RESP_SLVERR;

    // Data captured at the take, so later state changes cannot tear it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= xadl_pkg::RESP_OKAY;
            rdata_ff   <= 32'h0000_0000;
        end
        else
        begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            rresp_ff   <= ar_take ? nxt_rresp : rresp_ff;
            rdata_ff   <= ar_take ? {24'h00_0000, rd_byte} : rdata_ff;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign s_axi_awready    = awready_ff;
    assign s_axi_wready     = wready_ff;
    assign s_axi_bvalid     = bvalid_ff;
    assign s_axi_bresp      = bresp_ff;
    assign s_axi_arready    = arready_ff;
    assign s_axi_rvalid     = rvalid_ff;
    assign s_axi_rresp      = rresp_ff;
    assign s_axi_rdata      = rdata_ff;
    assign accumulator      = acc_ff;
    assign status_flags     = status_ff;
    assign port_a_direction = dir_ff[0];
    assign port_b_direction = dir_ff[1];
    assign port_c_direction = dir_ff[2];

endmodule

// ---- bench/xadl_chk_assertions.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the core
// ------------------------------------------------------------
module xadl_chk
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  accumulator,
    input wire logic [7:0]  status_flags,
    input wire logic [7:0]  port_a_direction,
    input wire logic [7:0]  port_b_direction,
    input wire logic [7:0]  port_c_direction
);
    logic [7:0]  aw_ff;
    logic [31:0] wd_ff;
    logic        run_ff;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Last write target; a word missing lane 0 or lane 2 never executes
    always_ff @(posedge aclk)
    begin
        run_ff <= aresetn;
        if (!aresetn) aw_ff <= 8'h00;
        else if (s_axi_awvalid && s_axi_awready) aw_ff <= s_axi_awaddr;
        if (!aresetn) wd_ff <= 32'h00000000;
        else if (s_axi_wvalid && s_axi_wready)
            wd_ff <= (s_axi_wstrb[0] && s_axi_wstrb[2]) ? s_axi_wdata : '0;
    end

    // Bus timing
    a_rd_latency: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_wr_latency: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after take");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");

    // Core state: only moves with a write answer, flags per instruction
    a_state_on_resp: assert property (run_ff && $changed({accumulator,
        status_flags, port_a_direction, port_b_direction, port_c_direction})
        |-> $rose(s_axi_bvalid)) else $error("state moved off a write");
    a_cdc_kept: assert property (
        run_ff && $changed(status_flags[1:0])
        |-> aw_ff == xadl_pkg::OFS_STATUS) else $error("carry bits moved");
    a_z_on_xor: assert property (
        run_ff && aw_ff == xadl_pkg::OFS_INSTR && $changed(accumulator)
        |-> status_flags[xadl_pkg::STAT_Z] == (accumulator == 8'h00))
        else $error("zero flag wrong");
    a_lit_result: assert property (
        aw_ff == xadl_pkg::OFS_INSTR && $rose(s_axi_bvalid) &&
        wd_ff[17:16] == xadl_pkg::XADL_OPC_LIT_XOR
        |-> accumulator == ($past(accumulator) ^ wd_ff[7:0]))
        else $error("literal xor result wrong");
    a_dir_copy: assert property (
        run_ff && $changed({port_a_direction, port_b_direction,
        port_c_direction}) |-> aw_ff == xadl_pkg::OFS_INSTR &&
        $stable(status_flags) && $stable(accumulator))
        else $error("direction moved wrongly");
    a_dir_value: assert property (run_ff |->
        (!$changed(port_a_direction) || port_a_direction == accumulator) &&
        (!$changed(port_b_direction) || port_b_direction == accumulator) &&
        (!$changed(port_c_direction) || port_c_direction == accumulator))
        else $error("direction not loaded from accumulator");

    // Main scenarios reached
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_dir_c: cover property (run_ff && $changed(port_c_direction));
    c_zero: cover property (run_ff && $rose(status_flags[2]));
endmodule

bind xadl_core xadl_chk u_chk
(
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .accumulator, .status_flags, .port_a_direction, .port_b_direction,
    .port_c_direction
);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // Signals; protection is held constant, lanes all on except in one literal-test word
    // ------------------------------------------------------------
    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic [2:0]  s_axi_awprot  = 3'h0;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata   = 32'h00000000;
    logic [3:0]  s_axi_wstrb   = 4'hF;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic [2:0]  s_axi_arprot  = 3'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    logic [7:0]  accumulator, status_flags;
    logic [7:0]  port_a_direction, port_b_direction, port_c_direction;
    int          n_errors      = 0;
    int          checks_done   = 0;

`define CHK(n, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("FAIL %s exp %0h got %0h", n, e, g); \
        end \
    end

    xadl_core uut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .accumulator, .status_flags, .port_a_direction, .port_b_direction,
        .port_c_direction
    );

    // ------------------------------------------------------------
    // Bus tasks; a wait ends by the answer or by the watchdog
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid)
            @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        `CHK("rdata", e, rdat)
        `CHK("rresp", xadl_pkg::RESP_OKAY, resp)
    endtask

    // Instruction word: opcode 17:16, destination 8, operand 7:0
    task automatic exe(input logic [1:0] op, input logic d,
                       input logic [7:0] k);
        wr(xadl_pkg::OFS_INSTR, {14'h0000, op, 7'h00, d, k});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_lit();
        wr(xadl_pkg::OFS_STATUS, 32'h000000FB);
        wr(xadl_pkg::OFS_ACC, 32'h0000005A);
        exe(xadl_pkg::XADL_OPC_LIT_XOR, 1'b0, 8'h5A);
        `CHK("acc", 8'h00, accumulator)
        `CHK("status", 8'hFF, status_flags)
        // Destination bit has no meaning for the literal form
        exe(xadl_pkg::XADL_OPC_LIT_XOR, 1'b1, 8'hFF);
        `CHK("status", 8'hFB, status_flags)
        rd(xadl_pkg::OFS_ACC, 32'h000000FF);
        // Opcode lane left out, so the word must not execute
        s_axi_wstrb <= 4'h1;
        exe(xadl_pkg::XADL_OPC_LIT_XOR, 1'b0, 8'h0F);
        s_axi_wstrb <= 4'hF;
        `CHK("acc", 8'hFF, accumulator)
        $display("literal xor test done");
    endtask

    task automatic t_file();
        wr(xadl_pkg::OFS_FADDR, 32'h0000007F);
        wr(xadl_pkg::OFS_FDATA, 32'h0000003C);
        wr(xadl_pkg::OFS_ACC, 32'h0000000F);
        wr(xadl_pkg::OFS_STATUS, 32'h00000003);
        exe(xadl_pkg::XADL_OPC_FILE_XOR, 1'b0, 8'h7F);
        `CHK("acc", 8'h33, accumulator)
        `CHK("status", 8'h03, status_flags)
        rd(xadl_pkg::OFS_FDATA, 32'h0000003C);
        exe(xadl_pkg::XADL_OPC_FILE_XOR, 1'b1, 8'h7F);
        `CHK("acc", 8'h33, accumulator)
        rd(xadl_pkg::OFS_FDATA, 32'h0000000F);
        wr(xadl_pkg::OFS_ACC, 32'h0000000F);
        exe(xadl_pkg::XADL_OPC_FILE_XOR, 1'b1, 8'h7F);
        `CHK("status", 8'h07, status_flags)
        rd(xadl_pkg::OFS_FDATA, 32'h00000000);
        // Address 128 lies outside the file and must not execute
        exe(xadl_pkg::XADL_OPC_FILE_XOR, 1'b0, 8'h80);
        `CHK("acc", 8'h0F, accumulator)
        rd(xadl_pkg::OFS_ERR, 32'h00000002);
        wr(xadl_pkg::OFS_ERR, 32'h00000003);
        `CHK("bresp", xadl_pkg::RESP_OKAY, resp)
        $display("file xor test done");
    endtask

    task automatic t_dir();
        logic [7:0] v [3];
        v = '{8'hFF, 8'hFF, 8'hFF};
        wr(xadl_pkg::OFS_STATUS, 32'h00000005);
        for (int s = 5; s <= 7; s++)
        begin
            wr(xadl_pkg::OFS_ACC, 32'(s * 16));
            exe(xadl_pkg::XADL_OPC_DIR_LOAD, 1'b0, 8'(s));
            v[s - 5] = 8'(s * 16);
            `CHK("dir a", v[0], port_a_direction)
            `CHK("dir b", v[1], port_b_direction)
            `CHK("dir c", v[2], port_c_direction)
            `CHK("status", 8'h05, status_flags)
        end
        // Neighbours of the legal range, then a direct store
        exe(xadl_pkg::XADL_OPC_DIR_LOAD, 1'b0, 8'h04);
        exe(xadl_pkg::XADL_OPC_DIR_LOAD, 1'b0, 8'h08);
        rd(xadl_pkg::OFS_ERR, 32'h00000001);
        wr(xadl_pkg::OFS_DIR_B, 32'h000000AA);
        `CHK("dir b", 8'h60, port_b_direction)
        wr(8'h40, 32'h00000000);
        `CHK("bresp", xadl_pkg::RESP_SLVERR, resp)
        rd(xadl_pkg::OFS_DIR_C, 32'h00000070);
        $display("direction load test done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Clock, reset, main sequence and a watchdog well past the run
    initial
    begin
        forever #20 aclk = ~aclk;
    end

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_lit();
        t_file();
        t_dir();
        end_sim();
    end

    initial
    begin
        #200000;
        n_errors++;
        end_sim();
    end
endmodule
